// *** verilog/dtc_top.sv ***
// dtc_top: APB register layer for two 8-bit timers that cascade into 16 bits.
// assumes APB3 master on pclk; pins are asynchronous and are synchronised inside.
`include "dtc_map.svh"
`default_nettype none
module dtc_top
  import dtc_pkg::*;
(
  input  wire  logic         pclk,
  input  wire  logic         presetn,
  input  wire  logic         psel,
  input  wire  logic         penable,
  input  wire  logic         pwrite,
  input  wire  logic [19:0]  paddr,
  input  wire  logic [31:0]  pwdata,
  output logic       [31:0]  prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire  logic         low_freq_clock_in,
  input  wire  logic         timer_a_pin_in,
  input  wire  logic         timer_b_pin_in,
  input  wire  logic         low_speed_mode,
  output logic               timer_a_out,
  output logic               timer_b_out
);
  dtc_apb_state_t    state_reg;
  logic [7:0]        timer_a_control_reg;
  logic [7:0]        timer_b_control_reg;
  logic [7:0]        timer_a_period_compare_reg;
  logic [7:0]        timer_b_period_compare_reg;
  logic [7:0]        timer_a_pulse_width_compare_reg;
  logic [7:0]        timer_b_pulse_width_compare_reg;
  logic              low_clock_divider_option_reg;
  logic [17:0]       index;
  logic              wr_en;
  logic              mapped;
  logic [31:0]       rdata_next;
  logic              cascade;
  logic              run_a_eff;
  logic              run_b;
  logic              ff_a_eff;
  logic              b_upper;
  logic [1:0]        tick;
  logic [1:0][2:0]   sel;
  logic              tick_b;
  logic              carry_a;
  logic [7:0]        count_a;
  logic [7:0]        count_b;
  dtc_mode_t         mode_a;
  dtc_mode_t         mode_b;

  assign index = paddr[19:2];
  // write lands on the access edge that also sees pready
  assign wr_en = psel && penable && pwrite && (state_reg == DTC_ST_ACK);

  // address decode over the word index
  always_comb
  begin
    mapped = 1'b1;
    rdata_next = 32'h0;
    case (index)
      `DTC_IDX_A_CTRL:   rdata_next = {24'h0, timer_a_control_reg};
      `DTC_IDX_B_CTRL:   rdata_next = {24'h0, timer_b_control_reg};
      `DTC_IDX_A_PERIOD: rdata_next = {24'h0, timer_a_period_compare_reg};
      `DTC_IDX_B_PERIOD: rdata_next = {24'h0, timer_b_period_compare_reg};
      `DTC_IDX_A_PWIDTH: rdata_next = {24'h0, timer_a_pulse_width_compare_reg};
      `DTC_IDX_B_PWIDTH: rdata_next = {24'h0, timer_b_pulse_width_compare_reg};
      `DTC_IDX_STATUS:   rdata_next = {14'h0, timer_b_out, timer_a_out, count_b, count_a};
      `DTC_IDX_CONFIG:   rdata_next = {31'h0, low_clock_divider_option_reg};
      default:           mapped = 1'b0;
    endcase
  end

  // apb handshake: one wait state, then pready for a single cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) state_reg <= DTC_ST_IDLE;
    else
      case (state_reg)
        DTC_ST_IDLE: if (psel && penable) state_reg <= DTC_ST_ACK;
        DTC_ST_ACK:  state_reg <= DTC_ST_IDLE;
        default:     state_reg <= DTC_ST_IDLE;
      endcase

  // answer flops, so the bus outputs come straight from registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else if (state_reg == DTC_ST_IDLE && psel && penable)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0 : rdata_next;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end

  // control registers; settings are taken as written, software keeps them still while running
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      timer_a_control_reg <= `DTC_CTRL_RESET; // R5
      timer_b_control_reg <= `DTC_CTRL_RESET; // R17
    end
    else if (wr_en && mapped)
    begin
      if (index == `DTC_IDX_A_CTRL) timer_a_control_reg <= pwdata[7:0]; // R1
      if (index == `DTC_IDX_B_CTRL) timer_b_control_reg <= pwdata[7:0]; // R13
    end

  // compare registers, all ones out of reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      timer_a_period_compare_reg      <= `DTC_CMP_RESET; // R4
      timer_a_pulse_width_compare_reg <= `DTC_CMP_RESET; // R4
      timer_b_period_compare_reg      <= `DTC_CMP_RESET;
      timer_b_pulse_width_compare_reg <= `DTC_CMP_RESET;
    end
    else if (wr_en && mapped)
      case (index)
        `DTC_IDX_A_PERIOD: timer_a_period_compare_reg      <= pwdata[7:0]; // R1
        `DTC_IDX_A_PWIDTH: timer_a_pulse_width_compare_reg <= pwdata[7:0]; // R1
        `DTC_IDX_B_PERIOD: timer_b_period_compare_reg      <= pwdata[7:0]; // R13
        `DTC_IDX_B_PWIDTH: timer_b_pulse_width_compare_reg <= pwdata[7:0]; // R13
        default: ;
      endcase

  // divider option for the slowest selection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_clock_divider_option_reg <= 1'b0;
    else if (wr_en && index == `DTC_IDX_CONFIG) low_clock_divider_option_reg <= pwdata[`DTC_DIVOPT_BIT];

  // cascade steering: timer a clock, timer b run and flip-flop
  assign cascade   = (timer_a_control_reg[`DTC_MODE_HI:`DTC_MODE_LO] == DTC_MODE_CASCADE); // R11
  assign run_b     = timer_b_control_reg[`DTC_RUN_BIT];
  assign run_a_eff = cascade ? run_b : timer_a_control_reg[`DTC_RUN_BIT]; // R12
  assign ff_a_eff  = cascade ? timer_b_control_reg[`DTC_FF_BIT] : timer_a_control_reg[`DTC_FF_BIT]; // R12
  assign b_upper   = timer_b_control_reg[`DTC_MODE_HI];
  assign mode_a    = dtc_mode_t'(timer_a_control_reg[`DTC_MODE_HI:`DTC_MODE_LO]);
  // upper byte sub-modes fold onto the 8-bit behaviours
  assign mode_b    = b_upper ? dtc_mode_t'({1'b0, timer_b_control_reg[1:0]})
                             : dtc_mode_t'(timer_b_control_reg[`DTC_MODE_HI:`DTC_MODE_LO]);
  assign sel[0]    = timer_a_control_reg[`DTC_CK_HI:`DTC_CK_LO]; // R12
  assign sel[1]    = timer_b_control_reg[`DTC_CK_HI:`DTC_CK_LO];
  // upper byte ignores its own clock select
  assign tick_b    = b_upper ? carry_a : tick[1]; // R16

  // source clock enables for both units
  dtc_clk_src u_clk_src (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     ({timer_b_pin_in, timer_a_pin_in, low_freq_clock_in}),
    .sel        (sel),
    .low_speed  (low_speed_mode),
    .div_option (low_clock_divider_option_reg),
    .tick       (tick)
  );

  // lower unit
  dtc_counter #(.W(8)) u_timer_a (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick[0]),
    .run     (run_a_eff),
    .mode    (mode_a),
    .ff_init (ff_a_eff),
    .period  (timer_a_period_compare_reg),
    .pwidth  (timer_a_pulse_width_compare_reg),
    .count   (count_a),
    .carry   (carry_a),
    .ff_out  (timer_a_out)
  );

  // upper unit, or an independent 8-bit timer
  dtc_counter #(.W(8)) u_timer_b (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_b),
    .run     (run_b),
    .mode    (mode_b),
    .ff_init (timer_b_control_reg[`DTC_FF_BIT]),
    .period  (timer_b_period_compare_reg),
    .pwidth  (timer_b_pulse_width_compare_reg),
    .count   (count_b),
    .carry   (),
    .ff_out  (timer_b_out)
  );

  property p_one_wait;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) // R18
    else $error("pready not a single cycle after one wait");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !mapped) |=> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not flagged");

  property p_ctrl_a_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && index == `DTC_IDX_A_CTRL) |=> (timer_a_control_reg == $past(pwdata[7:0]));
  endproperty
  a_ctrl_a_write: assert property (p_ctrl_a_write) // R5
    else $error("timer a control write lost");

  property p_ctrl_b_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && index == `DTC_IDX_B_CTRL) |=> (timer_b_control_reg == $past(pwdata[7:0]));
  endproperty
  a_ctrl_b_write: assert property (p_ctrl_b_write) // R17
    else $error("timer b control write lost");

  property p_period_readback;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && index == `DTC_IDX_A_PERIOD) |=> (timer_a_period_compare_reg == $past(pwdata[7:0]));
  endproperty
  a_period_readback: assert property (p_period_readback) // R4
    else $error("period compare read back differs");

  property p_cascade_stop;
    @(posedge pclk) disable iff (!presetn)
    (cascade && !run_b) |=> (count_a == 8'h00);
  endproperty
  a_cascade_stop: assert property (p_cascade_stop) // R12
    else $error("lower byte runs while upper unit is stopped");

  property p_upper_hold;
    @(posedge pclk) disable iff (!presetn)
    (b_upper && run_b && $past(run_b) && !carry_a && !wr_en) |=> $stable(count_b);
  endproperty
  a_upper_hold: assert property (p_upper_hold) // R16
    else $error("upper byte moved without a lower overflow");
endmodule
`default_nettype wire

// *** verilog/dtc_map.svh ***
// dtc_map.svh: register indexes, field positions, reset values for the dual timer.
// assumes an APB slave that decodes a word index, byte address = 4 * index.
// Overview of operation
// [R1] timer a has a control register plus 8-bit period and pulse-width compares
// [R2] software leaves timer a period compare alone while timer a runs
// [R3] pulse-width compare rewritten while running only in 8-bit or 16-bit pwm mode
// [R4] both timer a compare registers are read/write and reset to all ones
// [R5] control: bit7 flipflop, bits6-4 clock select, bit3 run, bits2-0 mode; reset zero
// [R6] clock codes pick fc/2^11 or fs/8, fc/2^7, fc/2^5, fc/2^3, fs, fc/2, fc, pin
// [R7] low-speed modes allow only fs/8, fs and fc (warm-up) selections
// [R8] run written 0 stops and clears the counter, written 1 starts counting
// [R9] modes: 000 timer/event, 001 divider out, 010 pwm, 011 cascade, 1xx reserved
// [R10] mode, clock and flipflop settings change only with the starting write
// [R11] software sets timer a mode to 011 for cascade; timer b picks sub-mode
// [R12] in cascade timer a clock select sources; run and flipflop from timer b
// [R13] timer b has its own control, period and pulse-width compare registers
// [R14] software leaves timer b period compare alone while timer b runs
// [R15] timer b pulse-width compare kept unchanged while running except pwm modes
// [R16] timer b mode 1xx counts timer a overflows, ignoring its clock select
// [R17] timer b control has the same layout as timer a and resets to zero
// [R18] writes act on the edge after the strobe; counting uses synchronised enables
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_IDX_A_CTRL    18'h00016
`define DTC_IDX_B_CTRL    18'h00017
`define DTC_IDX_A_PERIOD  18'h00018
`define DTC_IDX_B_PERIOD  18'h00019
`define DTC_IDX_A_PWIDTH  18'h1001a
`define DTC_IDX_B_PWIDTH  18'h1001b
`define DTC_IDX_STATUS    18'h00020
`define DTC_IDX_CONFIG    18'h00021
`define DTC_CTRL_RESET    8'h00
`define DTC_CMP_RESET     8'hff
`define DTC_FF_BIT        7
`define DTC_CK_HI         6
`define DTC_CK_LO         4
`define DTC_RUN_BIT       3
`define DTC_MODE_HI       2
`define DTC_MODE_LO       0
`define DTC_DIVOPT_BIT    0
`define DTC_PRESCALE_W    11
`define DTC_FS_DIV_W      3
`endif

// *** verilog/dtc_pkg.sv ***
// dtc_pkg: types shared by the dual timer modules.
// assumes dtc_map.svh for numeric constants.
`default_nettype none
package dtc_pkg;
  typedef enum logic [2:0] {
    DTC_MODE_TIMER   = 3'h0,
    DTC_MODE_PDO     = 3'h1,
    DTC_MODE_PWM     = 3'h2,
    DTC_MODE_CASCADE = 3'h3
  } dtc_mode_t;
  typedef enum logic [2:0] {
    DTC_CK_SLOWEST = 3'h0, DTC_CK_DIV7 = 3'h1, DTC_CK_DIV5 = 3'h2, DTC_CK_DIV3 = 3'h3,
    DTC_CK_FS      = 3'h4, DTC_CK_DIV1 = 3'h5, DTC_CK_FC   = 3'h6, DTC_CK_PIN  = 3'h7
  } dtc_clksel_t;
  typedef enum logic [1:0] {
    DTC_ST_IDLE = 2'b01,
    DTC_ST_ACK  = 2'b10
  } dtc_apb_state_t;
endpackage
`default_nettype wire

// *** verilog/dtc_clk_src.sv ***
// dtc_clk_src: count-enable pulses for both timers from prescaler, fs and pins.
// assumes pclk is the high-frequency clock; fs and pins are asynchronous.
`include "dtc_map.svh"
`default_nettype none
module dtc_clk_src
  import dtc_pkg::*;
(
  input  wire  logic             pclk,
  input  wire  logic             presetn,
  input  wire  logic [2:0]       pin_in,
  input  wire  logic [1:0][2:0]  sel,
  input  wire  logic             low_speed,
  input  wire  logic             div_option,
  output logic       [1:0]       tick
);
  logic [2:0]                   s1_reg, s2_reg, s3_reg;
  logic [2:0]                   rise;
  logic [`DTC_PRESCALE_W-1:0]   pre_reg;
  logic [`DTC_FS_DIV_W-1:0]     fs_cnt_reg;
  logic                         fs8;

  // two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  assign rise = s2_reg & ~s3_reg; // R18

  // free-running prescaler on the core clock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pre_reg <= '0;
    else pre_reg <= pre_reg + 1'b1;

  // fs divided by eight, counted on synchronised fs edges
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) fs_cnt_reg <= '0;
    else if (rise[0]) fs_cnt_reg <= fs_cnt_reg + 1'b1;
  assign fs8 = rise[0] && (&fs_cnt_reg);

  // per-unit source selection; unusable low-speed codes give no pulse
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    logic tick_reg;

    // one flop per unit, so each bit of tick has a single driver
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn) tick_reg <= 1'b0;
      else
        case (dtc_clksel_t'(sel[u]))
          DTC_CK_SLOWEST: tick_reg <= (low_speed || div_option) ? fs8 : (&pre_reg); // R6
          DTC_CK_DIV7:    tick_reg <= !low_speed && (&pre_reg[6:0]); // R7
          DTC_CK_DIV5:    tick_reg <= !low_speed && (&pre_reg[4:0]); // R7
          DTC_CK_DIV3:    tick_reg <= !low_speed && (&pre_reg[2:0]); // R7
          DTC_CK_FS:      tick_reg <= rise[0];
          DTC_CK_DIV1:    tick_reg <= !low_speed && pre_reg[0]; // R7
          DTC_CK_FC:      tick_reg <= 1'b1; // fc, warm-up use only in low speed
          DTC_CK_PIN:     tick_reg <= !low_speed && rise[u+1];
          default:        tick_reg <= 1'b0;
        endcase
    assign tick[u] = tick_reg;

    property p_low_speed_block;
      @(posedge pclk) disable iff (!presetn)
      (low_speed && sel[u] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7}) |=> !tick[u];
    endproperty
    a_low_speed_block: assert property (p_low_speed_block) // R7
      else $error("tick on a selection unusable in low speed");

    property p_fc_every_cycle;
      @(posedge pclk) disable iff (!presetn)
      (sel[u] == 3'h6) [*2] |-> tick[u];
    endproperty
    a_fc_every_cycle: assert property (p_fc_every_cycle) // R6
      else $error("fc selection did not tick every cycle");
  end
endmodule
`default_nettype wire

// *** verilog/dtc_counter.sv ***
// dtc_counter: one 8-bit counter with compare, overflow pulse and output flip-flop.
// assumes tick is a one-cycle enable on pclk; run low holds the counter at zero.
`include "dtc_map.svh"
`default_nettype none
module dtc_counter
  import dtc_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire  logic          pclk,
  input  wire  logic          presetn,
  input  wire  logic          tick,
  input  wire  logic          run,
  input  wire  dtc_mode_t     mode,
  input  wire  logic          ff_init,
  input  wire  logic [W-1:0]  period,
  input  wire  logic [W-1:0]  pwidth,
  output logic       [W-1:0]  count,
  output logic                carry,
  output logic                ff_out
);
  logic          run_d_reg;
  logic          at_period;
  logic          at_top;
  logic          live;

  assign at_period = (count == period);
  assign at_top    = (&count);
  assign live      = run && run_d_reg;

  // previous run level, to catch the start edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run_d_reg <= 1'b0;
    else run_d_reg <= run;

  // counting; stopped or just started means zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) count <= '0;
    else if (!live) count <= '0; // R8
    else if (tick)
      case (mode)
        DTC_MODE_TIMER, DTC_MODE_PDO: count <= at_period ? '0 : count + 1'b1; // R9
        DTC_MODE_PWM, DTC_MODE_CASCADE: count <= count + 1'b1;
        default: count <= count; // reserved codes do not count
      endcase

  // one-cycle overflow/match pulse, feeds the upper byte in cascade
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) carry <= 1'b0;
    else carry <= live && tick &&
                  (((mode == DTC_MODE_TIMER || mode == DTC_MODE_PDO) && at_period) ||
                   ((mode == DTC_MODE_PWM || mode == DTC_MODE_CASCADE) && at_top));

  // output flip-flop loaded at start, toggled by divider and pwm events
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ff_out <= 1'b0;
    else if (run && !run_d_reg) ff_out <= ff_init; // R5
    else if (live && tick)
      case (mode)
        DTC_MODE_PDO: if (at_period) ff_out <= ~ff_out;
        DTC_MODE_PWM: if ((count == pwidth) || at_top) ff_out <= ~ff_out;
        default:      ff_out <= ff_out;
      endcase

  property p_stop_clears;
    @(posedge pclk) disable iff (!presetn)
    !run |=> (count == '0);
  endproperty
  a_stop_clears: assert property (p_stop_clears) // R8
    else $error("counter not cleared while stopped");

  property p_period_wrap;
    @(posedge pclk) disable iff (!presetn)
    (live && tick && mode == DTC_MODE_TIMER && at_period) |=> (count == '0) && carry;
  endproperty
  a_period_wrap: assert property (p_period_wrap) // R9
    else $error("timer mode did not wrap at period match");

  property p_start_load;
    @(posedge pclk) disable iff (!presetn)
    $rose(run) |=> (ff_out == $past(ff_init));
  endproperty
  a_start_load: assert property (p_start_load) // R5
    else $error("flip-flop not loaded at start");
endmodule
`default_nettype wire

// *** verification/dual_timer_control_regs_bench.sv ***
// dual_timer_control_regs_bench: self-checking bench for the dual timer register layer.
// assumes dtc_top as the device, driven over APB at 50 MHz; pins toggled by the bench.
`default_nettype none
module dual_timer_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] A_CTRL = 20'h00058, B_CTRL = 20'h0005c, A_PER = 20'h00060, B_PER = 20'h00064;
  localparam logic [19:0] A_PW = 20'h40068, B_PW = 20'h4006c, STAT = 20'h00080, HOLE = 20'h00000;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [19:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        fs_in, pin_a, pin_b, low_speed, out_a, out_b;
  logic [31:0] rdata;
  logic        rerr;
  int          fail_count, n_compared, cycles, tg;

  dtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_freq_clock_in(fs_in), .timer_a_pin_in(pin_a), .timer_b_pin_in(pin_b),
    .low_speed_mode(low_speed), .timer_a_out(out_a), .timer_b_out(out_b));

  // 20 ns period core clock
  initial
  begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard: whole run needs well under 10k cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask

  // one apb transfer; request held until the edge where pready is seen high
  task apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // sample pready at rising edges only; the bench timeout ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [19:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rd(input logic [19:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // pulses on pin a (which 0) or the low-frequency input (which 1), wide enough for the syncs
  task pulses(input int which, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      if (which == 0) pin_a <= 1; else fs_in <= 1;
      repeat (4) @(posedge pclk);
      if (which == 0) pin_a <= 0; else fs_in <= 0;
      repeat (4) @(posedge pclk);
    end
  endtask

  // counts output a changes over a window, sampled mid-cycle
  task toggles(input int len);
    logic last;
    tg = 0;
    last = out_a;
    repeat (len)
    begin
      @(negedge pclk);
      if (out_a !== last) tg++;
      last = out_a;
    end
  endtask

  task t_reset;
    logic [19:0] adr [6] = '{A_CTRL, B_CTRL, A_PER, B_PER, A_PW, B_PW};
    logic [31:0] exp [6] = '{32'h0, 32'h0, 32'hff, 32'hff, 32'hff, 32'hff};
    for (int i = 0; i < 6; i++)
    begin
      rd(adr[i]);
      check(rdata, exp[i], "reset value");
    end
  endtask

  task t_regs;
    wr(A_PER, 8'h5a);
    wr(B_PW, 8'ha5);
    wr(B_PER, 8'h3c);
    rd(B_PER);
    check(rdata, 32'h3c, "b period readback");
    wr(B_CTRL, 8'hb1);
    rd(A_PER);
    check(rdata, 32'h5a, "a period readback");
    rd(B_PW);
    check(rdata, 32'ha5, "b pwidth readback");
    rd(B_CTRL);
    check(rdata, 32'hb1, "b control readback");
    wr(B_CTRL, 8'h00);
    wr(HOLE, 8'h33);
    check({31'h0, rerr}, 32'h1, "unmapped write error");
    rd(HOLE);
    check({31'h0, rerr}, 32'h1, "unmapped read error");
  endtask

  // timer mode, fc source, period 5; flip-flop preset on start
  task t_timer;
    wr(A_PER, 8'h05);
    wr(A_CTRL, 8'he8);
    @(posedge pclk);
    @(negedge pclk);
    check({31'h0, out_a}, 32'h1, "flipflop preset");
    repeat (4)
    begin
      rd(STAT);
      check({31'h0, rdata[7:0] <= 8'h05}, 32'h1, "count within period");
    end
    wr(A_CTRL, 8'he0);
    rd(STAT);
    check(rdata[7:0], 8'h00, "stop clears count");
  endtask

  task t_wave;
    wr(A_PER, 8'h03);
    wr(A_CTRL, 8'h69);
    toggles(40);
    check({31'h0, tg >= 9 && tg <= 11}, 32'h1, "divider toggles");
    wr(A_CTRL, 8'h61);
    wr(A_PW, 8'h40);
    wr(A_CTRL, 8'h6a);
    toggles(1024);
    check({31'h0, tg >= 7 && tg <= 9}, 32'h1, "pwm toggles");
    wr(A_CTRL, 8'h62);
  endtask

  // a as lower byte on fc, b upper byte with a slow clock code that must be ignored
  task t_cascade;
    wr(A_PER, 8'hff);
    wr(A_CTRL, 8'h63);
    wr(B_CTRL, 8'h1c);
    repeat (700) @(posedge pclk);
    rd(STAT);
    check(rdata[15:8], 8'h02, "upper byte counts carries");
    wr(B_CTRL, 8'h14);
    rd(STAT);
    check(rdata[7:0], 8'h00, "b run stops lower byte");
    wr(A_CTRL, 8'h00);
  endtask

  task t_low_speed;
    low_speed <= 1;
    wr(A_CTRL, 8'h18);
    repeat (50) @(posedge pclk);
    rd(STAT);
    check(rdata[7:0], 8'h00, "prescaled fc unusable");
    wr(A_CTRL, 8'h10);
    wr(A_CTRL, 8'h68);
    repeat (10) @(posedge pclk);
    rd(STAT);
    check({31'h0, rdata[7:0] != 8'h00}, 32'h1, "fc warm-up counts");
    wr(A_CTRL, 8'h60);
    low_speed <= 0;
  endtask

  task t_sources;
    wr(A_CTRL, 8'h78);
    pulses(0, 5);
    repeat (10) @(posedge pclk);
    rd(STAT);
    check(rdata[7:0], 8'h05, "pin edges counted");
    wr(A_CTRL, 8'h70);
    wr(B_CTRL, 8'h48);
    pulses(1, 3);
    repeat (10) @(posedge pclk);
    rd(STAT);
    check(rdata[15:8], 8'h03, "fs edges counted");
    wr(B_CTRL, 8'h40);
    wr(A_CTRL, 8'h6c);
    repeat (20) @(posedge pclk);
    rd(STAT);
    check(rdata[7:0], 8'h00, "reserved mode idle");
    wr(A_CTRL, 8'h64);
  endtask

  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    fs_in = 0; pin_a = 0; pin_b = 0; low_speed = 0;
    fail_count = 0; n_compared = 0; cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_regs();
    t_timer();
    t_wave();
    t_cascade();
    t_low_speed();
    t_sources();
    results();
  end
endmodule
`default_nettype wire
